// ---- hw/can_auto_store_pkg.sv ----
// Constants and types for the automatic receive store
package can_auto_store_pkg;
  // Look-up RAM geometry
  localparam int RAM_BYTES  = 2048;
  localparam int RAM_WORDS  = RAM_BYTES / 4;
  localparam int RAM_AW     = 9;
  localparam int PTR_W      = 12;
  localparam int IDX_W      = 10;
  localparam int MAX_OBJS   = 146;
  localparam int IRQ_OBJS   = 64;
  localparam int OBJ_WORDS  = 3;
  localparam int OBJ_BYTES  = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int WORD_LSB   = 2;
  // Word offsets of the data words inside an object
  localparam int DATA_LO_WORD = 1;
  localparam int DATA_HI_WORD = 2;
  // Semaphore codes
  localparam logic [1:0] SEM_UPDATING = 2'h1;
  localparam logic [1:0] SEM_DONE     = 2'h3;
  localparam logic [1:0] SEM_CPU      = 2'h0;
  // Identifier entry fields (one half-word)
  localparam int ENT_W         = 16;
  localparam int ENT_ID_LSB    = 0;
  localparam int ENT_IRQEN_BIT = 11;
  localparam int ENT_DIS_BIT   = 12;
  localparam int ENT_SCC_LSB   = 13;
  // Frame information word fields
  localparam int INFO_FF_BIT   = 31;
  localparam int INFO_RTR_BIT  = 30;
  localparam int INFO_LOST_BIT = 27;
  localparam int INFO_SEM_LSB  = 24;
  localparam int INFO_DLC_LSB  = 16;
  localparam int INFO_ID_LSB   = 0;

  typedef struct packed {
    logic [2:0]  scc;
    logic [10:0] id;
    logic        rtr;
    logic        frame_format_flag;
    logic [3:0]  dlc;
    logic [63:0] data;
  } rx_frame_t;

  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_SEARCH = 6'h02,
    ST_INFO   = 6'h04,
    ST_DATA1  = 6'h08,
    ST_DATA2  = 6'h10,
    ST_DONE   = 6'h20
  } store_state_t;

  typedef struct packed {
    store_state_t            st;
    logic [RAM_AW-1:0]       wptr;
    logic [IDX_W-1:0]        idx;
    logic                    irqen;
    logic                    lost;
    logic [IRQ_OBJS-1:0]     pend;
    logic                    res_v;
    logic                    res_hit;
    logic [IDX_W-1:0]        res_idx;
    logic [31:0]             rdata;
    logic                    rvalid;
  } store_regs_t;
endpackage : can_auto_store_pkg

// ---- hw/can_auto_receive_store.sv ----
// Automatic receive store: frame FIFO, table search and object writer
// Functional notes
// - Stored IDs get lowest indexes; others offset by half start pointer.
// - Standard frames search the stored-ID table before other tables.
// - Hit writes frame at table end plus index times twelve.
// - Object is info word then data bytes 1-4 and 5-8.
// - Semaphore 01 updating, 11 complete, 00 CPU reading.
// - Info word with semaphore 01 is written before any data.
// - After the last data word semaphore becomes 11.
// - Look-up RAM is 2 kB, up to 146 stored objects.
// - Only objects 0 to 63 raise interrupts; others still stored.
// - Pending flag set on store; request only with global enable.
// - Per-object interrupt enable and lost flag live in look-up RAM.
// - Lost flag (objects 0 to 63 with enable set) shows more than one frame stored since software last cleared the semaphore.
// - Pending set during the last write if object enable is set.
// - Pending cleared when software clears the object semaphore.
// - First write sets lost flag if pending, clears it otherwise.
`timescale 1ns/10ps

module can_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_regs_t;

  fifo_regs_t       r_ff;
  fifo_regs_t       nxt_r;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_out  = (r_ff.cnt != DEPTH[AW:0]);
  assign out_valid_out = (r_ff.cnt != '0);
  assign out_data_out  = mem[r_ff.rp];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always_comb begin
    nxt_r = r_ff;
    if (push) begin
      nxt_r.wp = r_ff.wp + 1'b1;
    end
    if (pop) begin
      nxt_r.rp = r_ff.rp + 1'b1;
    end
    nxt_r.cnt = r_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
    if (push) begin
      mem[r_ff.wp] <= in_data_in;
    end
  end
endmodule : can_rx_fifo

module can_auto_receive_store #(
  parameter int RAM_WORDS = can_auto_store_pkg::RAM_WORDS,
  parameter int DEPTH     = can_auto_store_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // Received frame from the CAN controllers
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  input  wire logic [2:0]  rx_scc_in,
  input  wire logic [10:0] rx_id_in,
  input  wire logic        rx_rtr_in,
  input  wire logic        rx_frame_format_flag_in,
  input  wire logic [3:0]  rx_dlc_in,
  input  wire logic [63:0] rx_data_in,
  // Configuration
  input  wire logic        auto_store_enable_in,
  input  wire logic        global_irq_enable_in,
  input  wire logic [11:0] std_individual_start_ptr_in,
  input  wire logic [11:0] table_end_ptr_in,
  // CPU access to look-up RAM
  input  wire logic        cpu_req_in,
  input  wire logic        cpu_we_in,
  input  wire logic [10:0] cpu_addr_in,
  input  wire logic [31:0] cpu_wdata_in,
  output logic [31:0]      cpu_rdata_out,
  output logic             cpu_rvalid_out,
  // Search results
  output logic             result_valid_out,
  output logic             result_hit_out,
  output logic [9:0]       match_index_out,
  output logic [9:0]       index_offset_out,
  output logic             busy_out,
  // Interrupts
  output logic [63:0]      object_irq_pending_out,
  output logic             irq_out
);
  localparam int AW   = can_auto_store_pkg::RAM_AW;
  localparam int IW   = can_auto_store_pkg::IDX_W;
  localparam int PTW  = can_auto_store_pkg::PTR_W;
  localparam int NIRQ = can_auto_store_pkg::IRQ_OBJS;
  localparam int PW   = $clog2(NIRQ);
  localparam int EW   = can_auto_store_pkg::ENT_W;
  localparam can_auto_store_pkg::store_regs_t REGS_RST = '{
    st:      can_auto_store_pkg::ST_IDLE,
    default: '0
  };

  can_auto_store_pkg::rx_frame_t   fifo_in;
  can_auto_store_pkg::rx_frame_t   head;
  logic                            head_valid;
  logic                            head_pop;
  can_auto_store_pkg::store_regs_t r_ff;
  can_auto_store_pkg::store_regs_t nxt_r;
  logic [31:0]                     ram [RAM_WORDS];
  logic                            hw_we;
  logic [AW-1:0]                   hw_addr;
  logic [31:0]                     hw_wdata;
  logic                            cpu_wr;
  logic [AW-1:0]                   cpu_word;
  logic [NIRQ-1:0]                 clr;
  logic [31:0]                     ent_word;
  logic [EW-1:0]                   entry;
  logic [2:0]                      ent_scc;
  logic [10:0]                     ent_id;
  logic [IW:0]                     n_entries;
  logic                            entry_hit;
  logic                            in_irq;
  logic                            lost_now;
  logic [PTW-1:0]                  obj_byte;
  logic [AW-1:0]                   obj_word;

  // Byte address of an object
  function automatic logic [PTW-1:0] obj_addr(
    input logic [PTW-1:0] base,
    input logic [IW-1:0]  idx
  );
    logic [PTW+3:0] sum;
    sum = {4'h0, base}
          + idx * (PTW + 4)'(can_auto_store_pkg::OBJ_BYTES);
    return sum[PTW-1:0];
  endfunction : obj_addr

  // First word of an object, unused bits zero
  function automatic logic [31:0] info_word(
    input can_auto_store_pkg::rx_frame_t f,
    input logic [1:0]                    sem,
    input logic                          lost
  );
    logic [31:0] w;
    w = '0;
    w[can_auto_store_pkg::INFO_FF_BIT]   = f.frame_format_flag;
    w[can_auto_store_pkg::INFO_RTR_BIT]  = f.rtr;
    w[can_auto_store_pkg::INFO_LOST_BIT] = lost;
    w[can_auto_store_pkg::INFO_SEM_LSB +: $bits(sem)] = sem;
    w[can_auto_store_pkg::INFO_DLC_LSB +: $bits(f.dlc)] = f.dlc;
    w[can_auto_store_pkg::INFO_ID_LSB +: $bits(f.id)]   = f.id;
    return w;
  endfunction : info_word

  // Frame FIFO
  assign fifo_in.scc               = rx_scc_in;
  assign fifo_in.id                = rx_id_in;
  assign fifo_in.rtr               = rx_rtr_in;
  assign fifo_in.frame_format_flag = rx_frame_format_flag_in;
  assign fifo_in.dlc               = rx_dlc_in;
  assign fifo_in.data              = rx_data_in;

  can_rx_fifo #(
    .WIDTH ($bits(can_auto_store_pkg::rx_frame_t)),
    .DEPTH (DEPTH)
  ) i_can_rx_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .in_data_in    (fifo_in),
    .out_valid_out (head_valid),
    .out_ready_in  (head_pop),
    .out_data_out  (head)
  );

  // Table entry decode
  assign cpu_wr    = cpu_req_in & cpu_we_in;
  assign cpu_word  = cpu_addr_in[$bits(cpu_addr_in)-1:can_auto_store_pkg::WORD_LSB];
  assign ent_word  = ram[r_ff.idx[IW-1:1]];
  assign entry     = r_ff.idx[0] ? ent_word[0 +: EW] : ent_word[EW +: EW];
  assign ent_scc   = entry[can_auto_store_pkg::ENT_SCC_LSB +: $bits(ent_scc)];
  assign ent_id    = entry[can_auto_store_pkg::ENT_ID_LSB +: $bits(ent_id)];
  assign n_entries = std_individual_start_ptr_in[PTW-1:1];
  assign entry_hit = !entry[can_auto_store_pkg::ENT_DIS_BIT]
                     && (ent_scc == head.scc)
                     && (ent_id == head.id);
  assign obj_byte  = obj_addr(table_end_ptr_in, r_ff.idx);
  assign obj_word  = obj_byte[AW+1:can_auto_store_pkg::WORD_LSB];
  assign in_irq    = (r_ff.idx < IW'(NIRQ));
  assign lost_now  = in_irq & r_ff.pend[r_ff.idx[PW-1:0]];

  // Store sequencer
  always_comb begin
    nxt_r        = r_ff;
    hw_we        = 1'b0;
    hw_addr      = r_ff.wptr;
    hw_wdata     = '0;
    head_pop     = 1'b0;
    nxt_r.res_v  = 1'b0;
    nxt_r.rvalid = cpu_req_in & ~cpu_we_in;
    if (cpu_req_in && !cpu_we_in) begin
      nxt_r.rdata = ram[cpu_word];
    end
    nxt_r.pend = r_ff.pend & ~clr;
    unique case (r_ff.st)
      can_auto_store_pkg::ST_IDLE: begin
        if (head_valid) begin
          if (auto_store_enable_in && !head.frame_format_flag) begin
            nxt_r.st  = can_auto_store_pkg::ST_SEARCH;
            nxt_r.idx = '0;
          end else begin
            head_pop      = 1'b1;
            nxt_r.res_v   = 1'b1;
            nxt_r.res_hit = 1'b0;
          end
        end
      end
      can_auto_store_pkg::ST_SEARCH: begin
        if ({1'b0, r_ff.idx} >= n_entries) begin
          head_pop      = 1'b1;
          nxt_r.res_v   = 1'b1;
          nxt_r.res_hit = 1'b0;
          nxt_r.st      = can_auto_store_pkg::ST_IDLE;
        end else if (entry_hit) begin
          nxt_r.res_v   = 1'b1;
          nxt_r.res_hit = 1'b1;
          nxt_r.res_idx = r_ff.idx;
          nxt_r.irqen   = entry[can_auto_store_pkg::ENT_IRQEN_BIT];
          nxt_r.wptr    = obj_word;
          nxt_r.st      = can_auto_store_pkg::ST_INFO;
        end else begin
          nxt_r.idx = r_ff.idx + 1'b1;
        end
      end
      can_auto_store_pkg::ST_INFO: begin
        hw_we      = 1'b1;
        hw_wdata   = info_word(head, can_auto_store_pkg::SEM_UPDATING,
                               lost_now);
        nxt_r.lost = lost_now;
        nxt_r.st   = can_auto_store_pkg::ST_DATA1;
      end
      can_auto_store_pkg::ST_DATA1: begin
        hw_we    = 1'b1;
        hw_addr  = r_ff.wptr + AW'(can_auto_store_pkg::DATA_LO_WORD);
        hw_wdata = head.data[31:0];
        nxt_r.st = can_auto_store_pkg::ST_DATA2;
      end
      can_auto_store_pkg::ST_DATA2: begin
        hw_we    = 1'b1;
        hw_addr  = r_ff.wptr + AW'(can_auto_store_pkg::DATA_HI_WORD);
        hw_wdata = head.data[63:32];
        nxt_r.st = can_auto_store_pkg::ST_DONE;
      end
      can_auto_store_pkg::ST_DONE: begin
        hw_we    = 1'b1;
        hw_wdata = info_word(head, can_auto_store_pkg::SEM_DONE,
                             r_ff.lost);
        head_pop = 1'b1;
        if (r_ff.irqen && in_irq) begin
          nxt_r.pend[r_ff.idx[PW-1:0]] = 1'b1;
        end
        nxt_r.st = can_auto_store_pkg::ST_IDLE;
      end
      default: begin
        nxt_r.st = can_auto_store_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      r_ff <= REGS_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Look-up RAM, hardware write wins a collision
  always_ff @(posedge clk_sys_in) begin
    if (cpu_wr) begin
      ram[cpu_word] <= cpu_wdata_in;
    end
    if (hw_we) begin
      ram[hw_addr] <= hw_wdata;
    end
  end

  // Pending clear on semaphore write of 00
  generate
    for (genvar j = 0; j < NIRQ; j++) begin : g_clr
      logic [PTW-1:0] info_addr;
      assign info_addr = obj_addr(table_end_ptr_in, IW'(j));
      assign clr[j] = cpu_wr
                      && (cpu_addr_in == info_addr[$bits(cpu_addr_in)-1:0])
                      && (cpu_wdata_in[can_auto_store_pkg::INFO_SEM_LSB +: 2]
                          == can_auto_store_pkg::SEM_CPU);
    end
  endgenerate

  // Outputs
  assign cpu_rdata_out          = r_ff.rdata;
  assign cpu_rvalid_out         = r_ff.rvalid;
  assign result_valid_out       = r_ff.res_v;
  assign result_hit_out         = r_ff.res_hit;
  assign match_index_out        = r_ff.res_idx;
  assign index_offset_out       = auto_store_enable_in ?
                                  std_individual_start_ptr_in[IW:1] :
                                  '0;
  assign busy_out               = (r_ff.st != can_auto_store_pkg::ST_IDLE)
                                  | head_valid;
  assign object_irq_pending_out = r_ff.pend;
  assign irq_out                = global_irq_enable_in & (|r_ff.pend);

  // Checks
  sequence s_data_words;
    (r_ff.st == can_auto_store_pkg::ST_DATA1)
    ##1 (r_ff.st == can_auto_store_pkg::ST_DATA2);
  endsequence

  property p_search_first;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st == can_auto_store_pkg::ST_IDLE) && head_valid
      && auto_store_enable_in && !head.frame_format_flag
      |=> (r_ff.st == can_auto_store_pkg::ST_SEARCH);
  endproperty
  a_search_first: assert property (p_search_first)
    else $error("stored-ID search not started");

  property p_info_first;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st == can_auto_store_pkg::ST_INFO)
      |-> hw_we && (hw_addr == obj_word)
          && (hw_wdata[can_auto_store_pkg::INFO_SEM_LSB +: 2]
              == can_auto_store_pkg::SEM_UPDATING);
  endproperty
  a_info_first: assert property (p_info_first)
    else $error("info word not written first with updating code");

  property p_obj_order;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st == can_auto_store_pkg::ST_INFO)
      |=> s_data_words ##1 (r_ff.st == can_auto_store_pkg::ST_DONE);
  endproperty
  a_obj_order: assert property (p_obj_order)
    else $error("object writes out of order");

  property p_done_sem;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st == can_auto_store_pkg::ST_DONE)
      |-> hw_we && (hw_addr == r_ff.wptr)
          && (hw_wdata[can_auto_store_pkg::INFO_SEM_LSB +: 2]
              == can_auto_store_pkg::SEM_DONE);
  endproperty
  a_done_sem: assert property (p_done_sem)
    else $error("semaphore not set complete on last write");

  property p_lost_first;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st == can_auto_store_pkg::ST_INFO)
      |-> (hw_wdata[can_auto_store_pkg::INFO_LOST_BIT] == lost_now);
  endproperty
  a_lost_first: assert property (p_lost_first)
    else $error("lost flag wrong on first write");

  property p_pend_set;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st == can_auto_store_pkg::ST_DONE) && r_ff.irqen && in_irq
      |=> r_ff.pend[r_ff.idx[PW-1:0]];
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("pending flag not set on last write");

  property p_pend_clear;
    @(posedge clk_sys_in) disable iff (rst_in)
      (r_ff.st != can_auto_store_pkg::ST_DONE) && clr[0]
      |=> !object_irq_pending_out[0];
  endproperty
  a_pend_clear: assert property (p_pend_clear)
    else $error("pending flag not cleared by semaphore write");

  property p_irq_gate;
    @(posedge clk_sys_in) disable iff (rst_in)
      !global_irq_enable_in |-> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("request raised with global enable off");
endmodule : can_auto_receive_store

// ---- dv/can_ctrl_model.sv ----
// CAN controller model handing frames over
`timescale 1ns/10ps
module can_ctrl_model (
  // Clock
  input  wire logic   clk_sys_in,
  // Frame hand-over
  output logic        rx_valid_out = 1'h0,
  input  wire logic   rx_ready_in,
  output logic [10:0] rx_id_out = 11'h0,
  output logic [63:0] rx_data_out = 64'h0
);
  task automatic send(input logic [10:0] id, input logic [63:0] d,
                      output logic ok);
    ok = 1'h0;
    @(posedge clk_sys_in);
    rx_valid_out <= 1'h1;
    rx_id_out    <= id;
    rx_data_out  <= d;
    for (int k = 0; k < 50 && !ok; k++) begin
      @(posedge clk_sys_in);
      ok = rx_ready_in;
    end
    rx_valid_out <= 1'h0;
    rx_id_out    <= ~id;
    rx_data_out  <= ~d;
  endtask : send
endmodule : can_ctrl_model

// ---- dv/can_auto_receive_store_tb_top.sv ----
// Bench for the automatic receive store
`timescale 1ns/10ps
module can_auto_receive_store_tb_top;
  logic        clk_sys_in = 1'h0;
  logic        rst_in = 1'h1;
  logic        req = 1'h0, we = 1'h0, gie = 1'h1, ext = 1'h0, ase = 1'h1;
  logic        rv, irq, vld, rdy, ok, res_v, res_hit, busy;
  logic        hit_q = 1'h0;
  logic [9:0]  mi, offs, idx_q = 10'h3ff;
  logic [10:0] id, addr = 11'h0;
  logic [63:0] pend, dat;
  logic [31:0] wd = 32'h0, rdv;
  int          n_fail = 0, comparisons = 0;
  localparam logic [63:0] D1 = 64'h8877_6655_4433_2211;
  localparam logic [63:0] D2 = 64'hf0de_bc9a_7856_3412;
  always #10 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) begin
    if (res_v === 1'h1) begin
      hit_q <= res_hit;
      idx_q <= mi;
    end
  end
  can_ctrl_model i_can_ctrl_model (.clk_sys_in, .rx_valid_out(vld),
    .rx_ready_in(rdy), .rx_id_out(id), .rx_data_out(dat));
  can_auto_receive_store i_can_auto_receive_store (.clk_sys_in, .rst_in,
    .rx_valid_in(vld), .rx_ready_out(rdy), .rx_scc_in(3'h0),
    .rx_id_in(id), .rx_rtr_in(1'h0), .rx_frame_format_flag_in(ext),
    .rx_dlc_in(4'h8), .rx_data_in(dat),
    .auto_store_enable_in(ase), .global_irq_enable_in(gie),
    .std_individual_start_ptr_in(12'h004),
    .table_end_ptr_in(12'h010),
    .cpu_req_in(req), .cpu_we_in(we), .cpu_addr_in(addr),
    .cpu_wdata_in(wd), .cpu_rdata_out(rdv), .cpu_rvalid_out(rv),
    .result_valid_out(res_v), .result_hit_out(res_hit),
    .match_index_out(mi), .index_offset_out(offs), .busy_out(busy),
    .object_irq_pending_out(pend), .irq_out(irq));
  task automatic chk(input string nm, input logic [63:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cpu(input logic w, input logic [10:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    req  <= 1'h1;
    we   <= w;
    addr <= a;
    wd   <= d;
    @(posedge clk_sys_in);
    req  <= 1'h0;
  endtask : cpu
  task automatic rd(input logic [10:0] a, input logic [31:0] e);
    cpu(1'h0, a, 32'h0);
    #1;
    chk("rvalid", rv, 1'h1);
    chk("word", rdv, e);
  endtask : rd
  task automatic settle;
    int k;
    for (k = 0; k < 60; k++) begin
      @(posedge clk_sys_in);
      #1;
      if (busy === 1'h0) break;
    end
    chk("idle", busy, 1'h0);
    if (busy !== 1'h0) disable main_seq;
    repeat (2) @(posedge clk_sys_in);
    #1;
  endtask : settle
  task automatic frame(input logic [10:0] fid, input logic [63:0] d);
    i_can_ctrl_model.send(fid, d, ok);
    chk("ready", ok, 1'h1);
    settle();
  endtask : frame
  initial begin
    begin : main_seq
      repeat (4) @(posedge clk_sys_in);
      rst_in <= 1'h0;
      cpu(1'h1, 11'h000, 32'h0923_1456);
      chk("offset", offs, 10'h002);
      frame(11'h123, D1);
      chk("hit", hit_q, 1'h1);
      chk("index", idx_q, 10'h000);
      chk("pend", pend, 64'h1);
      chk("irq", irq, 1'h1);
      rd(11'h010, 32'h0308_0123);
      rd(11'h014, 32'h4433_2211);
      rd(11'h018, 32'h8877_6655);
      frame(11'h123, D2);
      rd(11'h010, 32'h0b08_0123);
      rd(11'h014, 32'h7856_3412);
      cpu(1'h1, 11'h010, 32'h0);
      #1;
      chk("pend", pend, 64'h0);
      rd(11'h018, 32'hf0de_bc9a);
      rd(11'h010, 32'h0000_0000);
      frame(11'h123, D1);
      rd(11'h010, 32'h0308_0123);
      chk("pend", pend, 64'h1);
      @(posedge clk_sys_in);
      gie <= 1'h0;
      @(posedge clk_sys_in);
      #1;
      chk("irq", irq, 1'h0);
      chk("pend", pend, 64'h1);
      @(posedge clk_sys_in);
      ext <= 1'h1;
      frame(11'h123, D2);
      chk("hit", hit_q, 1'h0);
      rd(11'h014, 32'h4433_2211);
      @(posedge clk_sys_in);
      ext <= 1'h0;
      frame(11'h456, D2);
      chk("hit", hit_q, 1'h0);
      @(posedge clk_sys_in);
      ase <= 1'h0;
      #1;
      chk("offset", offs, 10'h000);
      frame(11'h123, D2);
      chk("hit", hit_q, 1'h0);
      rd(11'h010, 32'h0308_0123);
      @(posedge clk_sys_in);
      ase    <= 1'h1;
      gie    <= 1'h1;
      rst_in <= 1'h1;
      repeat (2) @(posedge clk_sys_in);
      rst_in <= 1'h0;
      #1;
      chk("pend", pend, 64'h0);
      chk("busy", busy, 1'h0);
      chk("rvalid", rv, 1'h0);
      frame(11'h123, D1);
      chk("index", idx_q, 10'h000);
      chk("irq", irq, 1'h1);
      rd(11'h010, 32'h0308_0123);
    end
    wrap_up();
  end
endmodule : can_auto_receive_store_tb_top
